// [src/vpw_bus_rx_break_arbitration.sv]
// Receive buffer, break detector, delay calibration and arbitration monitor
// of a single-wire serial bus interface, with an Avalon-MM register slave.
// Assumes a bit-level transmitter and receiver on the same clock feed the
// byte, bit and end-of-data strobes; the line pin is asynchronous, active = 1.
//
// Overview of operation
// - Debug mirror returns the receive byte; reading it keeps the full flag.
// - Each completed received byte loads the receive buffer and sets full flag.
// - Echoed transmit bytes enter the receive buffer like any other byte.
// - Receive DMA data comes from the receive buffer or the completion code.
// - Receive request while full flag and enable are set; buffer read clears.
// - Sending passive but seeing active is lost arbitration, not an error.
// - Sending active, seeing passive: policy 0 gives tx fault, 1 arbitration loss.
// - Calibration bit 6 reads zero and ignores writes.
// - Six-bit delay count compensates transceiver delay for transmit and arbitration.
// - Switching quad-speed mode reloads delay count: 23 normal, 7 quad.
// - Reading break status clears the break flag.
// - Break-over sets at break end; clears on zero write or new break.
// - Break-active high during break, falls just after break-over sets.
// - Break declared 240 us after line turns active; break flag sets then.
// - Break during a message posts corrupted code with break bit, ready set.
// - Break flag sets again every 4096 us while the break lasts.
// - Break end posts code with break bit, sets ready and break-over.
// - First good byte of a new message clears old completion bits.
// - Lost arbitration turns transmitter off; receiver goes on normally.
// - Lost arbitration sets lost, idle and empty flags together; clears counter.
// - Idle flag sets after last bit; ready sets at end of data; code read clears.
`timescale 1ns/1ps
module vpw_bus_rx_break_arbitration #(
   parameter int BREAK_US = vpw_pkg::BREAK_DETECT_US,
   parameter int REPEAT_US = vpw_pkg::BREAK_REPEAT_US,
   parameter int TICK_CYCLES = vpw_pkg::US_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic rx_pin,
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   input wire logic rx_first_good,
   input wire logic rx_msg_busy,
   input wire logic [2:0] rx_fault_code,
   input wire logic tx_begin,
   input wire logic tx_bit_start,
   input wire logic tx_bit_level,
   input wire logic tx_last_bit,
   input wire logic tx_eod,
   input wire logic tx_buf_taken,
   input wire logic cc_post,
   input wire logic [3:0] cc_code,
   input wire logic dma_rx_ack,
   output logic tx_enable,
   output logic tx_count_clear,
   output logic [5:0] cal_delay,
   output logic quad_speed_mode,
   output logic rx_int_req,
   output logic break_flag,
   output logic completion_ready,
   output logic [7:0] dma_rx_data
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic rx_s1, rx_s2, rx_s3, rx_level;
   logic [6:0] tick_cnt;
   logic [7:0] rx_data;
   logic rx_full;
   logic rx_full_int_enable;
   logic dma_src_code;
   logic arb_fault_policy;
   logic arb_lost_flag, tx_fault_bit, tx_idle_flag, tx_empty_flag;
   logic arb_wait, arb_lvl;
   logic [5:0] arb_cnt;
   logic [12:0] brk_us;
   logic break_active, break_over, brk_end_d;
   logic [3:0] ccode;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode: one wait state, then the access takes effect
   wire req = avs_read | avs_write;
   wire acc = req & ~avs_waitrequest;
   wire sel_mirror = avs_address == vpw_pkg::OFF_MIRROR;
   wire sel_rxbuf = avs_address == vpw_pkg::OFF_RXBUF;
   wire sel_cal = avs_address == vpw_pkg::OFF_CAL;
   wire sel_brk = avs_address == vpw_pkg::OFF_BRK;
   wire sel_ccode = avs_address == vpw_pkg::OFF_CCODE;
   wire sel_ctrl = avs_address == vpw_pkg::OFF_CTRL;
   wire sel_flags = avs_address == vpw_pkg::OFF_FLAGS;
   wire wr_acc = acc & avs_write;
   wire rd_acc = acc & avs_read;
   wire wr_rx = wr_acc & (sel_mirror | sel_rxbuf);
   wire wr_cal = wr_acc & sel_cal;
   wire wr_brk = wr_acc & sel_brk;
   wire wr_ctrl = wr_acc & sel_ctrl;
   wire wr_flags = wr_acc & sel_flags;
   wire rd_rxbuf = rd_acc & sel_rxbuf;
   wire rd_brk = rd_acc & sel_brk;
   wire rd_ccode = rd_acc & sel_ccode;
   wire [7:0] wd = avs_writedata[7:0];

   // Read multiplexer, unmapped offsets read zero
   wire [7:0] cal_rd = {arb_fault_policy, 1'b0, cal_delay};
   wire [7:0] brk_rd = {6'h00, break_over, break_active};
   wire [7:0] ctrl_rd = {5'h00, dma_src_code, quad_speed_mode, rx_full_int_enable};
   wire [7:0] flags_rd = {1'b0, break_flag, completion_ready, tx_empty_flag,
                          tx_idle_flag, tx_fault_bit, arb_lost_flag, rx_full};
   wire [7:0] rd_mux = (sel_mirror | sel_rxbuf) ? rx_data :
                       sel_cal ? cal_rd :
                       sel_brk ? brk_rd :
                       sel_ccode ? {4'h0, ccode} :
                       sel_ctrl ? ctrl_rd :
                       sel_flags ? flags_rd : 8'h00;

   // Waitrequest and read data registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else if (acc) begin
         avs_waitrequest <= 1'b1;
      end else if (req) begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= {24'h00_0000, rd_mux};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line synchroniser and microsecond tick
   wire us_tick = tick_cnt == 7'(TICK_CYCLES - 1);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rx_s1 <= 1'b0;
         rx_s2 <= 1'b0;
         rx_s3 <= 1'b0;
         rx_level <= 1'b0;
         tick_cnt <= 7'h00;
      end else begin
         rx_s1 <= rx_pin;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
         if (rx_s2 == rx_s3) begin
            rx_level <= rx_s3;
         end
         tick_cnt <= us_tick ? 7'h00 : tick_cnt + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive buffer, mirror and DMA source
   wire dma_take_rx = dma_rx_ack & ~dma_src_code;
   wire dma_take_cc = dma_rx_ack & dma_src_code;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rx_data <= vpw_pkg::RXBUF_RESET;
         rx_full <= 1'b0;
         rx_int_req <= 1'b0;
         dma_rx_data <= 8'h00;
      end else begin
         if (rx_byte_valid) begin
            rx_data <= rx_byte;
         end else if (wr_rx) begin
            rx_data <= wd;
         end
         if (rx_byte_valid) begin
            rx_full <= 1'b1;
         end else if (rd_rxbuf | dma_take_rx) begin
            rx_full <= 1'b0;
         end
         rx_int_req <= rx_full & rx_full_int_enable;
         dma_rx_data <= dma_src_code ? {4'h0, ccode} : rx_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and calibration registers
   wire quad_change = wr_ctrl & (wd[vpw_pkg::CTL_QUAD] != quad_speed_mode);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rx_full_int_enable <= vpw_pkg::CTRL_RESET[vpw_pkg::CTL_RXIE];
         quad_speed_mode <= vpw_pkg::CTRL_RESET[vpw_pkg::CTL_QUAD];
         dma_src_code <= vpw_pkg::CTRL_RESET[vpw_pkg::CTL_DMASRC];
         cal_delay <= vpw_pkg::CAL_NORMAL;
         arb_fault_policy <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            rx_full_int_enable <= wd[vpw_pkg::CTL_RXIE];
            quad_speed_mode <= wd[vpw_pkg::CTL_QUAD];
            dma_src_code <= wd[vpw_pkg::CTL_DMASRC];
         end
         if (quad_change) begin
            cal_delay <= wd[vpw_pkg::CTL_QUAD] ? vpw_pkg::CAL_QUAD : vpw_pkg::CAL_NORMAL;
         end else if (wr_cal) begin
            cal_delay <= wd[5:0];
         end
         if (wr_cal) begin
            arb_fault_policy <= wd[vpw_pkg::CAL_POLICY];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Arbitration check after the calibrated echo delay
   wire arb_chk = arb_wait & us_tick & (arb_cnt == 6'h00);
   wire lost_passive = arb_chk & ~arb_lvl & rx_level;
   wire mism_active = arb_chk & arb_lvl & ~rx_level;
   wire arb_lost_ev = lost_passive | (mism_active & arb_fault_policy);
   wire tx_fault_ev = mism_active & ~arb_fault_policy;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         arb_wait <= 1'b0;
         arb_cnt <= 6'h00;
         arb_lvl <= 1'b0;
      end else if (tx_bit_start & tx_enable) begin
         arb_wait <= 1'b1;
         arb_cnt <= cal_delay;
         arb_lvl <= tx_bit_level;
      end else if (arb_wait & us_tick) begin
         if (arb_cnt == 6'h00) begin
            arb_wait <= 1'b0;
         end else begin
            arb_cnt <= arb_cnt - 6'h01;
         end
      end
   end

   // Transmitter enable, counter clear and transmit flags (write 1 clears)
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tx_enable <= 1'b0;
         tx_count_clear <= 1'b0;
         arb_lost_flag <= 1'b0;
         tx_fault_bit <= 1'b0;
         tx_idle_flag <= vpw_pkg::TXIDLE_RESET;
         tx_empty_flag <= vpw_pkg::TXEMPTY_RESET;
      end else begin
         if (arb_lost_ev | tx_fault_ev | tx_last_bit) begin
            tx_enable <= 1'b0;
         end else if (tx_begin) begin
            tx_enable <= 1'b1;
         end
         tx_count_clear <= arb_lost_ev | tx_fault_ev;
         if (arb_lost_ev) begin
            arb_lost_flag <= 1'b1;
         end else if (wr_flags & wd[vpw_pkg::FLG_ARB]) begin
            arb_lost_flag <= 1'b0;
         end
         if (tx_fault_ev) begin
            tx_fault_bit <= 1'b1;
         end else if (wr_flags & wd[vpw_pkg::FLG_TXFAULT]) begin
            tx_fault_bit <= 1'b0;
         end
         if (arb_lost_ev | tx_last_bit) begin
            tx_idle_flag <= 1'b1;
         end else if ((wr_flags & wd[vpw_pkg::FLG_TXIDLE]) | tx_begin) begin
            tx_idle_flag <= 1'b0;
         end
         if (arb_lost_ev | tx_buf_taken) begin
            tx_empty_flag <= 1'b1;
         end else if ((wr_flags & wd[vpw_pkg::FLG_TXEMPTY]) | tx_begin) begin
            tx_empty_flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Break detection: active line timed in microseconds
   wire brk_decl = ~break_active & rx_level & us_tick & (brk_us == 13'(BREAK_US - 1));
   wire brk_rep = break_active & rx_level & us_tick & (brk_us == 13'(REPEAT_US - 1));
   wire brk_end = break_active & ~rx_level & ~brk_end_d;
   wire brk_corrupt = brk_decl & rx_msg_busy;
   wire [2:0] brk_fault = (rx_fault_code == 3'h0) ? 3'h1 : rx_fault_code;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         brk_us <= 13'h0000;
         break_active <= 1'b0;
         break_over <= 1'b0;
         brk_end_d <= 1'b0;
         break_flag <= 1'b0;
      end else begin
         if (!rx_level) begin
            brk_us <= 13'h0000;
         end else if (us_tick) begin
            brk_us <= (brk_decl | brk_rep) ? 13'h0000 : brk_us + 13'h0001;
         end
         brk_end_d <= brk_end;
         if (brk_decl) begin
            break_active <= 1'b1;
         end else if (brk_end_d) begin
            break_active <= 1'b0;
         end
         if (brk_end) begin
            break_over <= 1'b1;
         end else if (brk_decl | (wr_brk & ~wd[vpw_pkg::BRK_OVER])) begin
            break_over <= 1'b0;
         end
         if (brk_decl | brk_rep) begin
            break_flag <= 1'b1;
         end else if (rd_brk) begin
            break_flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Completion code and its ready flag
   wire cc_set = brk_corrupt | brk_end | tx_eod | cc_post;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ccode <= vpw_pkg::CCODE_RESET;
         completion_ready <= 1'b0;
      end else begin
         if (brk_corrupt) begin
            ccode <= {1'b1, brk_fault};
         end else if (brk_end) begin
            ccode[vpw_pkg::CC_BREAK] <= 1'b1;
         end else if (cc_post) begin
            ccode <= cc_code;
         end else if (rx_first_good) begin
            ccode <= vpw_pkg::CCODE_RESET;
         end
         if (cc_set) begin
            completion_ready <= 1'b1;
         end else if (rd_ccode | dma_take_cc) begin
            completion_ready <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   mirror_keeps_full_a: assert property (
      (rd_acc && sel_mirror && !rx_byte_valid && !dma_take_rx) |=> rx_full == $past(rx_full))
      else $error("mirror read changed full flag");
   rx_load_a: assert property (
      rx_byte_valid |=> (rx_data == $past(rx_byte)) && rx_full
      ##1 rx_int_req == $past(rx_full_int_enable))
      else $error("received byte not buffered");
   rxbuf_clear_a: assert property (
      (rd_rxbuf && !rx_byte_valid) |=> !rx_full ##1 !rx_int_req)
      else $error("buffer read did not clear full flag");
   arb_passive_a: assert property (
      lost_passive |=> arb_lost_flag && tx_idle_flag && tx_empty_flag && !tx_enable && tx_count_clear)
      else $error("lost arbitration flags wrong");
   arb_policy_a: assert property (
      (mism_active && !arb_fault_policy && !arb_lost_flag) |=> tx_fault_bit && !arb_lost_flag)
      else $error("policy zero did not give tx fault");
   cal_zero_bit_a: assert property (
      (avs_read && sel_cal && avs_waitrequest) |=> !avs_readdata[vpw_pkg::CAL_ZERO])
      else $error("calibration bit 6 not zero");
   quad_reload_a: assert property (
      quad_change |=> cal_delay == (quad_speed_mode ? vpw_pkg::CAL_QUAD : vpw_pkg::CAL_NORMAL))
      else $error("delay count not reloaded");
   break_decl_a: assert property (
      brk_decl |=> break_flag && break_active && !break_over)
      else $error("break declaration wrong");
   break_end_a: assert property (
      brk_end |=> break_over && break_active && completion_ready && ccode[vpw_pkg::CC_BREAK]
      ##1 !break_active)
      else $error("break end sequence wrong");
   break_read_a: assert property (
      (rd_brk && !brk_decl && !brk_rep) |=> !break_flag)
      else $error("break status read did not clear flag");

endmodule

// [src/vpw_pkg.sv]
// Shared constants of the single-wire bus receive, break and arbitration block.
// Assumes a 125 MHz system clock and a byte-addressed 32-bit register bus.
package vpw_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int US_NS = 1000;
   localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BREAK_DETECT_US = 240;
   localparam int BREAK_REPEAT_US = 4096;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [4:0] OFF_MIRROR = 5'h00;
   localparam logic [4:0] OFF_RXBUF = 5'h04;
   localparam logic [4:0] OFF_CAL = 5'h08;
   localparam logic [4:0] OFF_BRK = 5'h0C;
   localparam logic [4:0] OFF_CCODE = 5'h10;
   localparam logic [4:0] OFF_CTRL = 5'h14;
   localparam logic [4:0] OFF_FLAGS = 5'h18;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTL_RXIE = 0;
   localparam int CTL_QUAD = 1;
   localparam int CTL_DMASRC = 2;
   localparam int CAL_POLICY = 7;
   localparam int CAL_ZERO = 6;
   localparam int BRK_OVER = 1;
   localparam int BRK_ACTIVE = 0;
   localparam int FLG_RXFULL = 0;
   localparam int FLG_ARB = 1;
   localparam int FLG_TXFAULT = 2;
   localparam int FLG_TXIDLE = 3;
   localparam int FLG_TXEMPTY = 4;
   localparam int FLG_CCRDY = 5;
   localparam int FLG_BRK = 6;
   localparam int CC_BIT_FAULT = 0;
   localparam int CC_BYTERR = 1;
   localparam int CC_CHECKSUM_FAULT = 2;
   localparam int CC_BREAK = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Values after reset and defaults
   localparam logic [5:0] CAL_NORMAL = 6'h17;
   localparam logic [5:0] CAL_QUAD = 6'h07;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [3:0] CCODE_RESET = 4'h0;
   localparam logic [7:0] RXBUF_RESET = 8'h00;
   localparam logic TXIDLE_RESET = 1'b1;
   localparam logic TXEMPTY_RESET = 1'b1;

endpackage

// [test/tb_vpw_bus_rx_break_arbitration.sv]
// Self-checking bench of the receive, break and arbitration block.
// Assumes the Avalon-MM slave answers after one wait state and short tick counts.
`timescale 1ns/1ps
module tb_vpw_bus_rx_break_arbitration;
   typedef struct {logic wr; logic [4:0] a; logic [7:0] d;} reg_row_t;
   typedef struct {logic pol; logic lvl; logic oth; logic echo; logic [3:0] m; logic [3:0] e;
      logic en;} arb_row_t;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic rx_pin;
   logic [8:0] stb = 9'h000;
   logic [7:0] rx_byte = 8'h00;
   logic rx_msg_busy = 1'b0;
   logic [2:0] rx_fault_code = 3'h0;
   logic tx_bit_level = 1'b0;
   logic echo_on = 1'b0;
   logic other_active = 1'b0;
   logic [3:0] cc_code = 4'h0;
   logic tx_enable, tx_count_clear, quad_speed_mode, rx_int_req, break_flag, completion_ready;
   logic [5:0] cal_delay;
   logic [7:0] dma_rx_data;
   logic [7:0] rd;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int n_clr = 0;
   int k;
   reg_row_t regs[9];
   arb_row_t arbs[4];

   ////////////////////////////////////////////////////////////////////////////
   // Design, line model and clock
   vpw_bus_rx_break_arbitration #(.BREAK_US(16), .REPEAT_US(32), .TICK_CYCLES(4)) uut (
      .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin), .rx_byte_valid(stb[0]),
      .rx_byte(rx_byte), .rx_first_good(stb[1]), .rx_msg_busy(rx_msg_busy),
      .rx_fault_code(rx_fault_code), .tx_begin(stb[2]), .tx_bit_start(stb[3]),
      .tx_bit_level(tx_bit_level), .tx_last_bit(stb[4]), .tx_eod(stb[5]),
      .tx_buf_taken(stb[6]), .cc_post(stb[8]), .cc_code(cc_code), .dma_rx_ack(stb[7]),
      .tx_enable(tx_enable), .tx_count_clear(tx_count_clear), .cal_delay(cal_delay),
      .quad_speed_mode(quad_speed_mode), .rx_int_req(rx_int_req), .break_flag(break_flag),
      .completion_ready(completion_ready), .dma_rx_data(dma_rx_data));
   vpw_line_model #(.ECHO_CYCLES(8)) line (.sys_clk(sys_clk), .tx_enable(tx_enable),
      .tx_level(tx_bit_level), .echo_on(echo_on), .other_active(other_active), .rx_pin(rx_pin));
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   // Watchdog and clear-pulse counter
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (tx_count_clear === 1'b1) n_clr <= n_clr + 1;
      if (cycles == 20000) begin
         errors++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      if (wr) avs_write <= 1'b1;
      else avs_read <= 1'b1;
      @(posedge sys_clk);
      // Only the watchdog ends a wait that never completes
      while (avs_waitrequest !== 1'b0) begin
         @(posedge sys_clk);
      end
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic pulse(input int i);
      stb[i] <= 1'b1;
      @(posedge sys_clk);
      stb[i] <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic test_done();
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      regs = '{'{1, vpw_pkg::OFF_CAL, 8'hFF}, '{0, vpw_pkg::OFF_CAL, 8'hBF},
         '{1, vpw_pkg::OFF_CTRL, 8'h02}, '{0, vpw_pkg::OFF_CAL, 8'h87},
         '{0, vpw_pkg::OFF_CTRL, 8'h02}, '{1, vpw_pkg::OFF_CTRL, 8'h00},
         '{0, vpw_pkg::OFF_CAL, 8'h97}, '{1, 5'h1C, 8'hFF}, '{0, 5'h1C, 8'h00}};
      arbs = '{'{0, 1, 0, 1, 4'hF, 4'h0, 1}, '{0, 0, 1, 1, 4'hF, 4'hD, 0},
         '{0, 1, 0, 0, 4'h3, 4'h2, 0}, '{1, 1, 0, 0, 4'h3, 4'h1, 0}};
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      // Values after reset
      bus(0, vpw_pkg::OFF_CAL, 8'h00);
      chk(rd, 8'h17, "cal reset");
      bus(0, vpw_pkg::OFF_FLAGS, 8'h00);
      chk(rd, 8'h18, "flags reset");
      chk({2'h0, cal_delay}, 8'h17, "cal port");
      // Register rows
      foreach (regs[i]) begin
         bus(regs[i].wr, regs[i].a, regs[i].d);
         if (!regs[i].wr) chk(rd, regs[i].d, "reg row");
         if (i == 4) chk({1'b0, quad_speed_mode, cal_delay}, 8'h47, "quad port");
      end
      // Receive byte, mirror, buffer and DMA
      bus(1, vpw_pkg::OFF_CTRL, 8'h01);
      rx_byte <= 8'hA5;
      pulse(0);
      // Request and DMA data trail the full flag by one more edge
      @(posedge sys_clk);
      chk({7'h00, rx_int_req}, 8'h01, "rx request");
      chk(dma_rx_data, 8'hA5, "dma data");
      bus(0, vpw_pkg::OFF_MIRROR, 8'h00);
      chk(rd, 8'hA5, "mirror");
      bus(0, vpw_pkg::OFF_FLAGS, 8'h00);
      chk(rd & 8'h01, 8'h01, "full kept");
      bus(0, vpw_pkg::OFF_RXBUF, 8'h00);
      chk(rd, 8'hA5, "rx buffer");
      bus(0, vpw_pkg::OFF_FLAGS, 8'h00);
      chk(rd & 8'h01, 8'h00, "full cleared");
      chk({7'h00, rx_int_req}, 8'h00, "rx request off");
      rx_byte <= 8'h3C;
      pulse(0);
      pulse(7);
      bus(0, vpw_pkg::OFF_FLAGS, 8'h00);
      chk(rd & 8'h01, 8'h00, "dma clears full");
      // Arbitration rows, delay 5 us as software would program it
      foreach (arbs[i]) begin
         bus(1, vpw_pkg::OFF_CAL, {arbs[i].pol, 7'h05});
         bus(1, vpw_pkg::OFF_FLAGS, 8'h1E);
         pulse(2);
         k = n_clr;
         tx_bit_level <= arbs[i].lvl;
         echo_on <= arbs[i].echo;
         other_active <= arbs[i].oth;
         pulse(3);
         repeat (30) @(posedge sys_clk);
         other_active <= 1'b0;
         tx_bit_level <= 1'b0;
         @(posedge sys_clk);
         bus(0, vpw_pkg::OFF_FLAGS, 8'h00);
         chk({4'h0, rd[4:1] & arbs[i].m}, {4'h0, arbs[i].e}, "arb flags");
         chk({7'h00, tx_enable}, {7'h00, arbs[i].en}, "tx enable");
         chk({7'h00, n_clr > k}, {7'h00, ~arbs[i].en}, "count clear");
      end
      // Idle after last bit, ready after end of data
      pulse(2);
      pulse(4);
      pulse(6);
      bus(0, vpw_pkg::OFF_FLAGS, 8'h00);
      chk(rd & 8'h18, 8'h18, "idle empty");
      pulse(5);
      chk({7'h00, completion_ready}, 8'h01, "ready");
      bus(0, vpw_pkg::OFF_CCODE, 8'h00);
      chk({7'h00, completion_ready}, 8'h00, "ready cleared");
      // Long break during a message
      rx_msg_busy <= 1'b1;
      rx_fault_code <= 3'b100;
      other_active <= 1'b1;
      repeat (80) @(posedge sys_clk);
      chk({6'h00, break_flag, completion_ready}, 8'h03, "break declared");
      bus(0, vpw_pkg::OFF_BRK, 8'h00);
      chk(rd, 8'h01, "in break");
      chk({7'h00, break_flag}, 8'h00, "flag read clear");
      bus(0, vpw_pkg::OFF_CCODE, 8'h00);
      chk(rd, 8'h0C, "corrupt code");
      repeat (140) @(posedge sys_clk);
      chk({7'h00, break_flag}, 8'h01, "break repeat");
      other_active <= 1'b0;
      rx_msg_busy <= 1'b0;
      repeat (12) @(posedge sys_clk);
      chk({7'h00, completion_ready}, 8'h01, "break end ready");
      bus(0, vpw_pkg::OFF_BRK, 8'h00);
      chk(rd, 8'h02, "break over");
      bus(0, vpw_pkg::OFF_CCODE, 8'h00);
      chk(rd & 8'h08, 8'h08, "break code");
      bus(1, vpw_pkg::OFF_BRK, 8'h00);
      bus(0, vpw_pkg::OFF_BRK, 8'h00);
      chk(rd, 8'h00, "over cleared");
      pulse(1);
      bus(0, vpw_pkg::OFF_CCODE, 8'h00);
      chk(rd, 8'h00, "code cleared");
      // DMA from the completion code clears the ready flag
      bus(1, vpw_pkg::OFF_CTRL, 8'h04);
      cc_code <= 4'h5;
      pulse(8);
      @(posedge sys_clk);
      chk(dma_rx_data, 8'h05, "dma code");
      pulse(7);
      chk({7'h00, completion_ready}, 8'h00, "dma clears ready");
      test_done();
   end
endmodule

// [test/vpw_line_model.sv]
// Behavioural line side: transceiver echo of our own bits plus another node.
// Assumes one clock shared with the design; line active level is 1.
`timescale 1ns/1ps
module vpw_line_model #(
   parameter int ECHO_CYCLES = 8
) (
   input wire logic sys_clk,
   input wire logic tx_enable,
   input wire logic tx_level,
   input wire logic echo_on,
   input wire logic other_active,
   output logic rx_pin
);
   ////////////////////////////////////////////////////////////////////////////
   // Transceiver delay from driven level to received level
   logic [ECHO_CYCLES-1:0] echo_line = '0;
   always_ff @(posedge sys_clk) begin
      echo_line <= {echo_line[ECHO_CYCLES-2:0], tx_enable & tx_level & echo_on};
   end
   // Wired line: an active level from any node dominates
   assign rx_pin = echo_line[ECHO_CYCLES-1] | other_active;
endmodule
